/* core/sml_pkg.sv */
// sml_pkg: shared constants for the measurement-loop sequencer
// assumes a 32-bit apb register bus and a 20 mhz sample clock
package sml_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_PRETRG = 8'h08;
    localparam logic [7:0] OFS_TRGDLY = 8'h0c;
    localparam logic [7:0] OFS_BLKLEN = 8'h10;
    localparam logic [7:0] OFS_FREQ   = 8'h14;
    localparam logic [7:0] OFS_FILT   = 8'h18;
    localparam logic [7:0] OFS_STAT   = 8'h1c;
    // ctrl field positions
    localparam int CTRL_BLOCK   = 0;
    localparam int CTRL_INHIBIT = 1;
    localparam int CTRL_TRGDRV  = 2;
    localparam int CTRL_XDEC    = 3;
    // cmd field positions
    localparam int CMD_SYNC = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_CLRO = 2;
    // reset values
    localparam logic [3:0]  CTRL_RST   = 4'h1;
    localparam logic [15:0] BLKLEN_RST = 16'h0040;
    // loop states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_ARM     = 4'b0010,
        ST_TRIGGER = 4'b0100,
        ST_MEASURE = 4'b1000
    } sml_state_t;
endpackage

/* core/sml_loop.sv */
// sml_loop: measurement-loop sequencer with zoom mixer, decimation and fifo
// assumes clk is the shared adc sample clock, one sample per cycle,
// and that every peer samples the wired-or sync line on this same clock
`timescale 1ns/1ps

// What this block does
// - four states, all but continuous measure moved by sync edges
// - idle stores nothing, old data readable
// - arm clears fifo, waits sync release
// - arm holds sync until pretrigger filled
// - trigger entered only when all released
// - trigger keeps only pretrigger window
// - command or trigger asserts sync, measure
// - output starts at window start plus delay
// - block mode holds sync until block
// - continuous releases; stop or overflow idles
// - every edge acts in every module
// - setting blocks idle to arm
// - continuous run accepts synced frequency change
// - complex oscillator mixes samples to dc
// - octaves past first drop alternate samples
// - optional extra decimation by two
// - decimation counter chooses kept samples
// - sync sets oscillator phase and decimation
// - sync changes only right after edges
// - prepared filter: next edge restarts counter
// - block mode frequency edge needs idle
module sml_loop
    import sml_pkg::*;
#(
    parameter int DW = 16,                // sample width
    parameter int AW = 8                  // fifo address width
) (
    input  wire logic          clk,       // shared sample clock
    input  wire logic          rst,       // async reset, high
    input  wire logic [31:0]   paddr,     // apb address
    input  wire logic          psel,      // apb select
    input  wire logic          penable,   // apb enable
    input  wire logic          pwrite,    // apb direction
    input  wire logic [31:0]   pwdata,    // apb write data
    output logic      [31:0]   prdata,    // apb read data
    output logic               pready,    // apb ready
    output logic               pslverr,   // apb error
    input  wire logic          syncIn,    // sync line level
    output logic               syncOut,   // sync drive value
    output logic               syncOe_n,  // low while driving
    input  wire logic [DW-1:0] adcData,   // adc sample
    input  wire logic          trigHit,   // trigger condition
    output logic      [DW-1:0] outI,      // output in-phase
    output logic      [DW-1:0] outQ,      // output quadrature
    output logic               outValid,  // output valid
    input  wire logic          outReady   // output ready
);
    localparam int DEPTH = 1 << AW;
    localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

    // ==========================================================
    // registers
    sml_state_t        state;
    logic [3:0]        ctrl;
    logic [15:0]       preTrig;
    logic [15:0]       trigDly;
    logic [15:0]       blkLen;
    logic [31:0]       freqWord;
    logic [31:0]       freqPend;
    logic              freqArmed;
    logic [3:0]        filtOct;
    logic [3:0]        filtPend;
    logic              filtArmed;
    logic              overflow;
    logic              driveSync;
    logic              s1, s2, s3, syncLevel, syncPrev;
    logic [31:0]       phase;
    logic [7:0]        decCnt;
    logic [AW:0]       wrPtr, rdPtr, startPtr;
    logic [2*DW-1:0]   mem [DEPTH];

    // refused addresses must not reach the command or register decode
    wire apbWr = psel && penable && pwrite && paddr[31:8] == 24'h0;
    wire cmdWr = apbWr && paddr[7:0] == OFS_CMD;
    wire cmdSync = cmdWr && pwdata[CMD_SYNC];
    wire cmdStop = cmdWr && pwdata[CMD_STOP];
    wire filtWr  = apbWr && paddr[7:0] == OFS_FILT;

    // ==========================================================
    // sync pin input
    // three stages; a level counts once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            syncLevel <= 1'b0;
            syncPrev <= 1'b0;
        end else begin
            s1 <= syncIn;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                syncLevel <= s3;
            end
            syncPrev <= syncLevel;
        end
    end
    // identical edge detect in all peers
    wire syncRise = syncLevel && !syncPrev;
    wire syncFall = !syncLevel && syncPrev;
    // arm entry; a pending change takes the edge instead
    wire armGo = state == ST_IDLE && syncRise && !ctrl[CTRL_INHIBIT] && !freqArmed && !filtArmed;

    // ==========================================================
    // fifo occupancy and write decision
    wire [AW:0] fill = wrPtr - rdPtr;
    wire        full = fill == DEPTH_W;
    wire [AW:0] stored = wrPtr - startPtr;
    logic       keep;
    wire        storing = state != ST_IDLE && keep;
    wire        overrun = storing && full && state == ST_MEASURE && !ctrl[CTRL_BLOCK];
    wire        blockDone = stored >= (AW+1)'(blkLen) + (AW+1)'(trigDly);

    // ==========================================================
    // loop state machine
    // state moves on sync edges, on stop or overrun in continuous measure, and on a filter write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else if (filtWr) begin
            // a prepared filter change ends any measurement
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (syncRise && !ctrl[CTRL_INHIBIT] && !freqArmed && !filtArmed) begin
                        state <= ST_ARM;
                    end
                end
                // line low means every peer released
                ST_ARM: begin
                    if (syncFall) begin
                        state <= ST_TRIGGER;
                    end
                end
                ST_TRIGGER: begin
                    if (syncRise) begin
                        state <= ST_MEASURE;
                    end
                end
                ST_MEASURE: begin
                    if (ctrl[CTRL_BLOCK] ? syncFall : (cmdStop || overrun)) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // sync drive; flop output so edges follow clk closely
    // drive changes only after a clock edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            driveSync <= 1'b0;
        end else begin
            case (state)
                // request holds until seen; a due pretrigger keeps it into arm,
                // since a one-cycle dip would look like a release to peers
                ST_IDLE: begin
                    driveSync <= cmdSync || (driveSync && !syncLevel)
                        || (armGo && preTrig != 16'h0);
                end
                ST_ARM: driveSync <= stored < (AW+1)'(preTrig);
                // a one-cycle command would be filtered out; hold until seen
                ST_TRIGGER: begin
                    driveSync <= cmdSync || (ctrl[CTRL_TRGDRV] && trigHit)
                        || (driveSync && !syncLevel) || (syncRise && ctrl[CTRL_BLOCK]);
                end
                ST_MEASURE: driveSync <= ctrl[CTRL_BLOCK] && !blockDone;
                default: driveSync <= 1'b0;
            endcase
        end
    end
    // open-drain style: drive high only, else float
    assign syncOut  = 1'b1;
    assign syncOe_n = !driveSync;

    // ==========================================================
    // oscillator and pending changes
    // block mode applies only when idle
    wire freqGo = syncRise && freqArmed &&
        (state == ST_IDLE || (state == ST_MEASURE && !ctrl[CTRL_BLOCK]));
    wire filtGo = (syncRise || syncFall) && filtArmed && state == ST_IDLE;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            freqWord <= 32'h0;
            freqArmed <= 1'b0;
            phase <= 32'h0;
        end else begin
            if (freqGo) begin
                freqWord <= freqPend;
                freqArmed <= 1'b0;
                phase <= 32'h0;
            end else begin
                if (apbWr && paddr[7:0] == OFS_FREQ) begin
                    freqArmed <= 1'b1;
                end
                phase <= phase + freqWord;
            end
        end
    end

    // counter restarts on the next edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            filtOct <= 4'h0;
            filtArmed <= 1'b0;
            decCnt <= 8'h00;
        end else if (filtGo) begin
            filtOct <= filtPend;
            filtArmed <= 1'b0;
            decCnt <= 8'h00;
        end else begin
            if (filtWr) begin
                filtArmed <= 1'b1;
            end
            decCnt <= decCnt + 8'h01;
        end
    end

    // ==========================================================
    // mixer: coarse eight-point cosine table keeps area small
    function automatic logic signed [7:0] cosLut(input logic [2:0] p);
        case (p)
            3'h0: cosLut = 8'sh7f;
            3'h1: cosLut = 8'sh5a;
            3'h2: cosLut = 8'sh00;
            3'h3: cosLut = -8'sh5a;
            3'h4: cosLut = -8'sh7f;
            3'h5: cosLut = -8'sh5a;
            3'h6: cosLut = 8'sh00;
            default: cosLut = 8'sh5a;
        endcase
    endfunction
    // multiply by cos - j sin
    wire signed [DW+7:0] prodI = $signed(adcData) * cosLut(phase[31:29]);
    wire signed [DW+7:0] prodQ = -($signed(adcData) * cosLut(phase[31:29] - 3'h2));

    // keep one of two per octave past the first
    // extra halving widens the mask by one bit
    // counter low bits select kept samples
    always_comb begin
        logic [7:0] mask;
        mask = 8'h00;
        if (filtOct > 4'h1) begin
            mask = (8'h01 << (filtOct - 4'h1)) - 8'h01;
        end
        if (ctrl[CTRL_XDEC]) begin
            mask = {mask[6:0], 1'b1};
        end
        keep = (decCnt & mask) == 8'h00;
    end

    // ==========================================================
    // fifo write side
    always_ff @(posedge clk) begin
        if (storing && !overrun) begin
            mem[wrPtr[AW-1:0]] <= {prodI[DW+6:7], prodQ[DW+6:7]};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            startPtr <= '0;
        end else if (armGo) begin
            wrPtr <= '0;
            startPtr <= '0;
        end else begin
            if (storing && !overrun) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (state == ST_TRIGGER && syncRise) begin
                startPtr <= wrPtr - (AW+1)'(preTrig);
            end
        end
    end

    // ==========================================================
    // fifo read side
    wire avail = fill != '0 && fill <= DEPTH_W;
    wire readOk = state == ST_IDLE || state == ST_MEASURE;
    assign outValid = avail && readOk;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdPtr <= '0;
        end else if (armGo) begin
            rdPtr <= '0;
        end else if (state == ST_TRIGGER && syncRise) begin
            // first output is pretrigger window start plus delay
            rdPtr <= wrPtr - (AW+1)'(preTrig) + (AW+1)'(trigDly);
        end else if ((state == ST_ARM || state == ST_TRIGGER) && storing
                     && (full || fill >= (AW+1)'(preTrig))) begin
            // drop samples older than the window
            rdPtr <= rdPtr + 1'b1;
        end else if (outValid && outReady) begin
            rdPtr <= rdPtr + 1'b1;
        end
    end
    assign outI = mem[rdPtr[AW-1:0]][2*DW-1:DW];
    assign outQ = mem[rdPtr[AW-1:0]][DW-1:0];

    // ==========================================================
    // apb slave, zero wait states
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= CTRL_RST;
            preTrig <= 16'h0;
            trigDly <= 16'h0;
            blkLen <= BLKLEN_RST;
            freqPend <= 32'h0;
            filtPend <= 4'h0;
        end else if (apbWr) begin
            case (paddr[7:0])
                OFS_CTRL:   ctrl <= pwdata[3:0];
                OFS_PRETRG: preTrig <= pwdata[15:0];
                OFS_TRGDLY: trigDly <= pwdata[15:0];
                OFS_BLKLEN: blkLen <= pwdata[15:0];
                OFS_FREQ:   freqPend <= pwdata;
                OFS_FILT:   filtPend <= pwdata[3:0];
                default: ;
            endcase
        end
    end
    // overflow flag; a new overrun wins over a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow <= 1'b0;
        end else if (overrun) begin
            overflow <= 1'b1;
        end else if (cmdWr && pwdata[CMD_CLRO]) begin
            overflow <= 1'b0;
        end
    end

    wire mapped = paddr[31:8] == 24'h0 && paddr[1:0] == 2'b00 && paddr[7:0] <= OFS_STAT;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    always_comb begin
        case (paddr[7:0])
            OFS_CTRL:   prdata = {28'h0, ctrl};
            OFS_PRETRG: prdata = {16'h0, preTrig};
            OFS_TRGDLY: prdata = {16'h0, trigDly};
            OFS_BLKLEN: prdata = {16'h0, blkLen};
            OFS_FREQ:   prdata = freqPend;
            OFS_FILT:   prdata = {28'h0, filtPend};
            OFS_STAT:   prdata = {7'h0, fill, 8'h0, filtArmed, freqArmed,
                                  overflow, syncLevel, state};
            default:    prdata = 32'h0;
        endcase
    end

    // ==========================================================
    // checks
    sequence armEntry;
        state == ST_IDLE ##1 state == ST_ARM;
    endsequence
    idle_no_write_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_IDLE && $past(state) == ST_IDLE
        |=> $stable(wrPtr) || (state == ST_ARM && wrPtr == '0))
        else $error("fifo written in idle");
    arm_clears_a: assert property (@(posedge clk) disable iff (rst)
        armEntry |-> wrPtr <= 1 && rdPtr == 0)
        else $error("arm entry did not clear fifo");
    arm_release_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_ARM && stored >= (AW+1)'(preTrig) |=> !driveSync)
        else $error("sync held after pretrigger filled");
    trig_entry_a: assert property (@(posedge clk) disable iff (rst)
        $rose(state == ST_TRIGGER) |-> $past(syncFall))
        else $error("trigger entered without release");
    meas_entry_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_TRIGGER && syncRise && !filtWr |=> state == ST_MEASURE)
        else $error("assertion did not start measure");
    cont_release_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_MEASURE && !ctrl[CTRL_BLOCK] |=> !driveSync)
        else $error("continuous mode kept sync");
    inhibit_hold_a: assert property (@(posedge clk) disable iff (rst)
        state == ST_IDLE && ctrl[CTRL_INHIBIT] |=> state == ST_IDLE)
        else $error("inhibit ignored");
    freq_apply_a: assert property (@(posedge clk) disable iff (rst)
        syncRise && freqArmed && state == ST_MEASURE && ctrl[CTRL_BLOCK]
        |=> freqArmed)
        else $error("frequency applied in block measure");
    dec_restart_a: assert property (@(posedge clk) disable iff (rst)
        filtGo |=> decCnt == 8'h00 ##1 decCnt == 8'h01)
        else $error("decimation counter not restarted");
endmodule // sml_loop

/* dv/sml_peer.sv */
// sml_peer: behavioural peer digitizer sharing the sync line
// assumes the device's sample clock and a pulled-down wired-or line
`timescale 1ns/1ps
module sml_peer (
    input  wire logic       clk,      // shared sample clock
    input  wire logic       rst,      // async reset, high
    input  wire logic       lineLvl,  // resolved sync line
    input  wire logic       cmdSync,  // one-cycle assert request
    input  wire logic [7:0] armHold,  // cycles held in arm
    input  wire logic [7:0] measHold, // cycles held in measure
    output logic            oe_n      // low while driving
);
    // ==========================================================
    // loop state and line edges
    logic [1:0] st;   // 0 idle, 1 arm, 2 trigger, 3 measure
    logic [7:0] cnt;  // remaining hold cycles
    logic       lvlD; // line one cycle back
    logic       rise;
    logic       fall;
    assign rise = lineLvl & ~lvlD;
    assign fall = ~lineLvl & lvlD;
    // hold, release, assert
    // every drive change lands just after an edge, never near one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st   <= 2'd0;
            cnt  <= 8'h00;
            lvlD <= 1'b0;
            oe_n <= 1'b1;
        end else begin
            lvlD <= lineLvl;
            if (st == 2'd0 || st == 2'd2) begin
                if (rise) begin
                    st   <= st + 2'd1;
                    cnt  <= (st == 2'd0) ? armHold : measHold;
                    oe_n <= ((st == 2'd0) ? armHold : measHold) == 8'h00;
                end else if (cmdSync) begin
                    oe_n <= 1'b0;
                end
            end else begin
                // release when done; the line falls only when all let go
                if (cnt != 8'h00)
                    cnt <= cnt - 8'h01;
                else
                    oe_n <= 1'b1;
                if (fall)
                    st <= st + 2'd1;
            end
        end
    end
endmodule // sml_peer

/* dv/testbench.sv */
// testbench: self-checking bench for the measurement-loop sequencer
// assumes one peer model on the wired-or sync line, pulled down
`timescale 1ns/1ps
module testbench
    import sml_pkg::*;
();
    // ==========================================================
    // signals
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rdData;
    logic        syncOut, syncOe_n, trigHit, outValid, outReady;
    logic        lineLvl, pCmd, peerOe_n, rdErr;
    logic [15:0] adcData, outI, outQ;
    logic [7:0]  pArm, pMeas;
    int          nMismatch, nChecks;
    assign lineLvl = (~syncOe_n & syncOut) | ~peerOe_n;
    sml_loop sml_loop_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .syncIn(lineLvl), .syncOut(syncOut),
        .syncOe_n(syncOe_n), .adcData(adcData), .trigHit(trigHit), .outI(outI),
        .outQ(outQ), .outValid(outValid), .outReady(outReady));
    sml_peer sml_peer_inst (.clk(clk), .rst(rst), .lineLvl(lineLvl), .cmdSync(pCmd),
        .armHold(pArm), .measHold(pMeas), .oe_n(peerOe_n));
    // ==========================================================
    // clock, ramp samples, watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) adcData <= adcData + 16'h0001;
    initial begin
        repeat (30000) @(posedge clk);
        nMismatch++;
        closeOut();
    end
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; result left in rdData and rdErr
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {24'h0, a};
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdData = prdata;
        rdErr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // poll status until the state shows up, bounded
    task automatic waitSt(input sml_state_t s);
        int i;
        i = 0;
        rd(OFS_STAT);
        while (rdData[3:0] !== s && i < 400) begin
            rd(OFS_STAT);
            i++;
        end
    endtask
    task automatic stCheck(input sml_state_t s);
        waitSt(s);
        chk(32'(rdData[3:0]), 32'(s));
    endtask
    task automatic peerPulse();
        @(posedge clk);
        pCmd <= 1'b1;
        @(posedge clk);
        pCmd <= 1'b0;
    endtask
    // trigger hit held until measure is reached
    task automatic trigMeas();
        @(posedge clk);
        trigHit <= 1'b1;
        waitSt(ST_MEASURE);
        trigHit <= 1'b0;
        chk(32'(rdData[3:0]), 32'(ST_MEASURE));
    endtask
    // continuous loop up to measure by command in trigger
    task automatic contRun();
        wr(OFS_CTRL, 32'h4);
        wr(OFS_CMD, 32'h1);
        waitSt(ST_TRIGGER);
        wr(OFS_CMD, 32'h1);
        stCheck(ST_MEASURE);
    endtask
    // ==========================================================
    // scenarios
    task automatic scRegs();
        rd(OFS_CTRL);
        chk(rdData, 32'(CTRL_RST));
        rd(OFS_BLKLEN);
        chk(rdData, 32'(BLKLEN_RST));
        stCheck(ST_IDLE);
        rd(8'h20);
        chk({rdData[30:0], rdErr}, 32'h1);
    endtask
    task automatic scBlock();
        int i, n, q;
        logic [8:0] fill;
        logic [15:0] prevI;
        pArm <= 8'd60;
        wr(OFS_BLKLEN, 32'h8);
        wr(OFS_CTRL, 32'h5);
        wr(OFS_CMD, 32'h1);
        stCheck(ST_ARM);
        // a slow peer still holds the line after we let go
        i = 0;
        while (syncOe_n !== 1'b1 && i < 100) begin
            @(posedge clk);
            i++;
        end
        repeat (8) @(posedge clk);
        chk(32'(lineLvl), 32'h1);
        stCheck(ST_ARM);
        stCheck(ST_TRIGGER);
        trigMeas();
        stCheck(ST_IDLE);
        rd(OFS_STAT);
        fill = rdData[24:16];
        repeat (30) @(posedge clk);
        rd(OFS_STAT);
        chk(32'(rdData[24:16]), 32'(fill));
        // drain stored block; baseband leaves quadrature at zero
        n = 0;
        q = 0;
        outReady <= 1'b1;
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            if (outValid === 1'b1) begin
                n++;
                if (outQ !== 16'h0000) q++;
                // ramp scaled by the zero-phase cosine steps by 0 or 1
                if (n > 1 && (outI - prevI) !== 16'h0000 && (outI - prevI) !== 16'h0001) q++;
                prevI = outI;
            end
        end
        outReady <= 1'b0;
        chk(32'(n >= 8 && n <= 256), 32'h1);
        chk(32'(q), 32'h0);
    endtask
    task automatic scInhibit();
        pArm  <= 8'd8;
        pMeas <= 8'd8;
        wr(OFS_CTRL, 32'h3);
        peerPulse();
        repeat (30) @(posedge clk);
        stCheck(ST_IDLE);
        peerPulse();
        repeat (30) @(posedge clk);
        stCheck(ST_IDLE);
        wr(OFS_CTRL, 32'h5);
    endtask
    task automatic scPretrig();
        int c;
        pArm <= 8'd0;
        wr(OFS_PRETRG, 32'd20);
        wr(OFS_CMD, 32'h1);
        c = 0;
        while (lineLvl !== 1'b1 && c < 50) begin
            @(posedge clk);
            c++;
        end
        c = 0;
        while (lineLvl === 1'b1 && c < 200) begin
            @(posedge clk);
            c++;
        end
        chk(32'(c >= 20 && c <= 34), 32'h1);
        stCheck(ST_TRIGGER);
        trigMeas();
        stCheck(ST_IDLE);
        wr(OFS_PRETRG, 32'd0);
    endtask
    task automatic scCont();
        logic [8:0] f0;
        outReady <= 1'b1;
        contRun();
        repeat (20) @(posedge clk);
        chk(32'(syncOe_n), 32'h1);
        repeat (100) @(posedge clk);
        stCheck(ST_MEASURE);
        wr(OFS_CMD, 32'h2);
        stCheck(ST_IDLE);
        // stalled sink lets the fifo overflow
        outReady <= 1'b0;
        contRun();
        stCheck(ST_IDLE);
        chk(32'(rdData[5]), 32'h1);
        wr(OFS_CMD, 32'h4);
        rd(OFS_STAT);
        chk(32'(rdData[5]), 32'h0);
        // frequency change rides a peer edge without stopping
        outReady <= 1'b1;
        pArm <= 8'd8;
        contRun();
        wr(OFS_FREQ, 32'h1);
        rd(OFS_STAT);
        chk(32'(rdData[6]), 32'h1);
        peerPulse();
        repeat (30) @(posedge clk);
        stCheck(ST_MEASURE);
        chk(32'(rdData[6]), 32'h0);
        // filter change forces idle; the next peer edge applies it
        wr(OFS_FILT, 32'h2);
        rd(OFS_STAT);
        chk(32'(rdData[7:0]), 32'h81);
        peerPulse();
        repeat (30) @(posedge clk);
        rd(OFS_STAT);
        chk(32'(rdData[7:0]), 32'h01);
        // second octave keeps every other sample: 43 edges store 21 or 22
        outReady <= 1'b0;
        contRun();
        rd(OFS_STAT);
        f0 = rdData[24:16];
        repeat (40) @(posedge clk);
        rd(OFS_STAT);
        f0 = rdData[24:16] - f0;
        chk(32'(f0 == 9'd21 || f0 == 9'd22), 32'h1);
    endtask
    // ==========================================================
    // verdict and main sequence
    task automatic closeOut();
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {rst, psel, penable, pwrite, trigHit, outReady, pCmd} = 7'h40;
        {paddr, pwdata} = 64'h0;
        adcData = 16'h0000;
        {pArm, pMeas} = 16'h0;
        nMismatch = 0;
        nChecks = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        scRegs();
        scBlock();
        scInhibit();
        scPretrig();
        scCont();
        closeOut();
    end
endmodule // testbench
